// ===== logic/cvc_top.sv
// Purpose: comparator change flag, enables and ladder control registers
// Assumes: AHB-Lite slave, zero wait states, one 200 MHz clock
// Notes:   comparator results arrive asynchronously and are synchronised
//
// The placing of the registers and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`include "cvc_defines.svh"

module cvc_top (
    // clock and reset
    input  wire logic       CLK_IN,
    input  wire logic       RST_IN,
    // ahb-lite slave
    input  wire logic       HSEL_IN,
    input  wire logic [7:0] HADDR_IN,
    input  wire logic [1:0] HTRANS_IN,
    input  wire logic       HWRITE_IN,
    input  wire logic [2:0] HSIZE_IN,
    input  wire logic [31:0] HWDATA_IN,
    input  wire logic       HREADY_IN,
    output logic            HREADYOUT_OUT,
    output logic            HRESP_OUT,
    output logic [31:0]     HRDATA_OUT,
    // analog side
    input  wire logic [1:0] CMP_RAW_IN,
    input  wire logic       SLEEP_IN,
    output logic [5:0]      CMP_CTRL_OUT,
    output logic [7:0]      REF_CTRL_OUT,
    output logic [7:0]      REF_LEVEL_OUT,
    output logic [7:0]      PORTF_DIR_OUT,
    output logic            PINS_ANALOG_OUT,
    // core side
    output logic            IRQ_OUT,
    output logic            IRQ_PRIO_OUT,
    output logic            WAKE_OUT
);

    // ============================================================
    // state
    cvc_pkg::cvc_cmp_ctrl_t cmp_ctrl_q;
    cvc_pkg::cvc_ref_ctrl_t ref_ctrl_q;
    logic                   global_en_q;
    logic                   periph_en_q;
    logic                   change_flag_q;
    logic                   change_flag_d;
    logic                   change_en_q;
    logic                   change_prio_q;
    logic [7:0]             portf_dir_q;
    logic [3:0]             conv_cfg_q;
    logic [1:0]             raw_meta_q;
    logic [1:0]             raw_sync_q;
    logic [1:0]             latched_q;
    logic [1:0]             result;
    logic                   mismatch;
    logic                   wr_pend_q;
    logic [7:0]             wr_addr_q;
    logic                   addr_take;
    logic                   wr_flags;

    // ============================================================
    // helpers
    // read value of one register, unmapped reads give zero
    function automatic logic [7:0] rd_byte(input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            `CVC_OFS_CMP_CTRL:   v = {result, cmp_ctrl_q};
            `CVC_OFS_REF_CTRL:   v = ref_ctrl_q;
            `CVC_OFS_CORE_IRQ: begin
                v[`CVC_BIT_GLOBAL_EN] = global_en_q;
                v[`CVC_BIT_PERIPH_EN] = periph_en_q;
            end
            `CVC_OFS_REQ_FLAGS2: v[`CVC_BIT_CHANGE] = change_flag_q;
            `CVC_OFS_REQ_EN2:    v[`CVC_BIT_CHANGE] = change_en_q;
            `CVC_OFS_REQ_PRIO2:  v[`CVC_BIT_CHANGE] = change_prio_q;
            `CVC_OFS_PORTF_DIR:  v = portf_dir_q;
            `CVC_OFS_CONV_CFG:   v = {4'h0, conv_cfg_q};
            default:             v = 8'h00;
        endcase
        return v;
    endfunction : rd_byte

    // ladder level in 96ths of span
    function automatic logic [7:0] ladder_level(input logic rng,
                                                input logic [3:0] tap);
        logic [7:0] t;
        t = {4'h0, tap};
        if (rng) begin
            ladder_level = 8'(t * `CVC_LOW_STEP);
        end else begin
            ladder_level = 8'(`CVC_HIGH_BASE + t * `CVC_HIGH_STEP);
        end
    endfunction : ladder_level

    // ============================================================
    // bus decode
    // single wait-free slave: no read-after-write hazard, since the
    // master idles through every data phase
    assign addr_take = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
    assign wr_flags  = wr_pend_q & (wr_addr_q == `CVC_OFS_REQ_FLAGS2);

    // write pending into the data phase
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= addr_take & HWRITE_IN;
            if (addr_take) begin
                wr_addr_q <= HADDR_IN;
            end
        end
    end

    // read data is staged for the data phase; response always okay
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            HRDATA_OUT    <= 32'h0000_0000;
            HREADYOUT_OUT <= 1'b1;
            HRESP_OUT     <= 1'b0;
        end else begin
            HREADYOUT_OUT <= 1'b1;
            HRESP_OUT     <= 1'b0;
            if (addr_take & ~HWRITE_IN) begin
                HRDATA_OUT <= {24'h00_0000, rd_byte(HADDR_IN)};
            end else begin
                HRDATA_OUT <= 32'h0000_0000;
            end
        end
    end

    // ============================================================
    // comparator results
    // first stage feeds only the second; relatch_a also reads it
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            raw_meta_q <= 2'b00;
            raw_sync_q <= 2'b00;
        end else begin
            raw_meta_q <= CMP_RAW_IN;
            raw_sync_q <= raw_meta_q;
        end
    end

    // results read as zero while comparators are off
    always_comb begin
        if (cmp_ctrl_q.comparator_mode_field == `CVC_MODE_OFF) begin
            result = 2'b00;
        end else begin
            result = raw_sync_q ^ {cmp_ctrl_q.second_result_invert,
                                   cmp_ctrl_q.first_result_invert};
        end
    end

    assign mismatch = (result != latched_q);

    // any access to comparator control relatches; a change landing in
    // that same cycle still sets the flag, as its mismatch is seen first
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            latched_q <= 2'b00;
        end else if (addr_take && HADDR_IN == `CVC_OFS_CMP_CTRL) begin
            latched_q <= result;
        end
    end

    // ============================================================
    // change flag: hardware set beats software clear
    always_comb begin
        change_flag_d = change_flag_q;
        if (wr_flags) begin
            change_flag_d = HWDATA_IN[`CVC_BIT_CHANGE];
        end
        if (mismatch) begin
            change_flag_d = 1'b1;
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            change_flag_q <= 1'b0;
        end else begin
            change_flag_q <= change_flag_d;
        end
    end

    // ============================================================
    // control registers; sleep never resets any of them
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            cmp_ctrl_q <= `CVC_RST_CMP_CTRL;
        end else if (wr_pend_q && wr_addr_q == `CVC_OFS_CMP_CTRL) begin
            cmp_ctrl_q <= HWDATA_IN[5:0];
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ref_ctrl_q <= `CVC_RST_REF_CTRL;
        end else if (wr_pend_q && wr_addr_q == `CVC_OFS_REF_CTRL) begin
            ref_ctrl_q <= HWDATA_IN[7:0];
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            global_en_q   <= 1'b0;
            periph_en_q   <= 1'b0;
            change_en_q   <= 1'b0;
            change_prio_q <= 1'b0;
        end else if (wr_pend_q) begin
            case (wr_addr_q)
                `CVC_OFS_CORE_IRQ: begin
                    global_en_q <= HWDATA_IN[`CVC_BIT_GLOBAL_EN];
                    periph_en_q <= HWDATA_IN[`CVC_BIT_PERIPH_EN];
                end
                `CVC_OFS_REQ_EN2:   change_en_q <= HWDATA_IN[`CVC_BIT_CHANGE];
                `CVC_OFS_REQ_PRIO2: begin
                    change_prio_q <= HWDATA_IN[`CVC_BIT_CHANGE];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            portf_dir_q <= `CVC_RST_PORTF_DIR;
            conv_cfg_q  <= `CVC_RST_CONV_CFG;
        end else if (wr_pend_q && wr_addr_q == `CVC_OFS_PORTF_DIR) begin
            portf_dir_q <= HWDATA_IN[7:0];
        end else if (wr_pend_q && wr_addr_q == `CVC_OFS_CONV_CFG) begin
            conv_cfg_q <= HWDATA_IN[3:0];
        end
    end

    // ============================================================
    // outputs, all registered one cycle after their source
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            IRQ_OUT         <= 1'b0;
            IRQ_PRIO_OUT    <= 1'b0;
            WAKE_OUT        <= 1'b0;
            CMP_CTRL_OUT    <= 6'h00;
            REF_CTRL_OUT    <= 8'h00;
            REF_LEVEL_OUT   <= 8'h00;
            PORTF_DIR_OUT   <= 8'h00;
            PINS_ANALOG_OUT <= 1'b1;
        end else begin
            IRQ_OUT <= change_flag_q & change_en_q
                       & periph_en_q & global_en_q;
            IRQ_PRIO_OUT <= change_prio_q;
            // wake needs only the change enable, as in sleep
            WAKE_OUT <= SLEEP_IN & change_flag_q & change_en_q;
            CMP_CTRL_OUT <= cmp_ctrl_q;
            REF_CTRL_OUT <= ref_ctrl_q;
            REF_LEVEL_OUT <= ladder_level(ref_ctrl_q.reference_range_select,
                                          ref_ctrl_q.reference_tap_value);
            // pin driver off while the ladder drives the shared pin
            PORTF_DIR_OUT <= portf_dir_q
                | {2'b00, ref_ctrl_q.reference_pin_output_enable, 5'h00};
            PINS_ANALOG_OUT <= (conv_cfg_q != `CVC_CFG_ALL_DIGITAL);
        end
    end

    // ============================================================
    // checks
    change_sets_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        mismatch |=> change_flag_q)
        else $error("flag missed a result change");

    flag_holds_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        change_flag_q && !wr_flags |=> change_flag_q)
        else $error("flag cleared itself");

    soft_set_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        wr_flags && HWDATA_IN[`CVC_BIT_CHANGE] |=> change_flag_q)
        else $error("software set of flag lost");

    irq_gate_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        ##1 IRQ_OUT == $past(change_flag_q && change_en_q
                             && periph_en_q && global_en_q))
        else $error("interrupt output gating wrong");

    disabled_flag_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        mismatch && !global_en_q |=> change_flag_q && !IRQ_OUT)
        else $error("flag not set with interrupts disabled");

    relatch_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        addr_take && HADDR_IN == `CVC_OFS_CMP_CTRL
        && raw_meta_q == raw_sync_q && !wr_pend_q |=> !mismatch)
        else $error("control access did not end mismatch");

    sync_path_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        !RST_IN |-> ##2 raw_sync_q == $past(CMP_RAW_IN, 2))
        else $error("synchroniser depth wrong");

    wake_path_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        SLEEP_IN && change_flag_q && change_en_q |=> WAKE_OUT)
        else $error("no wake on enabled change in sleep");

    level_calc_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        ref_ctrl_q.reference_range_select && $stable(ref_ctrl_q)
        |=> REF_LEVEL_OUT == 8'({4'h0,
                                 $past(ref_ctrl_q.reference_tap_value)}
                                * `CVC_LOW_STEP))
        else $error("low range level wrong");

    off_mode_a: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        cmp_ctrl_q.comparator_mode_field == `CVC_MODE_OFF
        |-> result == 2'b00)
        else $error("results not zero with comparators off");

    change_seen_c: cover property (@(posedge CLK_IN) disable iff (RST_IN)
        !change_flag_q ##1 change_flag_q ##[1:20] IRQ_OUT);
    clear_seq_c: cover property (@(posedge CLK_IN) disable iff (RST_IN)
        change_flag_q ##1 wr_flags && !mismatch ##1 !change_flag_q);
    wake_seen_c: cover property (@(posedge CLK_IN) disable iff (RST_IN)
        SLEEP_IN ##1 WAKE_OUT);

endmodule : cvc_top

// ===== logic/cvc_defines.svh
// Purpose: named offsets, bit positions and reset values of the block
// Assumes: AHB-Lite word registers, byte addresses below
// Notes:   definitions only
`ifndef CVC_DEFINES_SVH
`define CVC_DEFINES_SVH

// ============================================================
// register byte offsets
`define CVC_OFS_CMP_CTRL     8'h00
`define CVC_OFS_REF_CTRL     8'h04
`define CVC_OFS_CORE_IRQ     8'h08
`define CVC_OFS_REQ_FLAGS2   8'h0C
`define CVC_OFS_REQ_EN2      8'h10
`define CVC_OFS_REQ_PRIO2    8'h14
`define CVC_OFS_PORTF_DIR    8'h18
`define CVC_OFS_CONV_CFG     8'h1C

// ============================================================
// field positions
`define CVC_BIT_SECOND_RES   7
`define CVC_BIT_FIRST_RES    6
`define CVC_BIT_CHANGE       6
`define CVC_BIT_GLOBAL_EN    7
`define CVC_BIT_PERIPH_EN    6
`define CVC_BIT_REF_PIN      5

// ============================================================
// reset values and codes
`define CVC_RST_CMP_CTRL     6'h07
`define CVC_RST_REF_CTRL     8'h00
`define CVC_RST_PORTF_DIR    8'hFF
`define CVC_RST_CONV_CFG     4'h0
`define CVC_MODE_OFF         3'h7
`define CVC_CFG_ALL_DIGITAL  4'hF

// ============================================================
// ladder level in 96ths of the source span
`define CVC_LOW_STEP         8'h04
`define CVC_HIGH_STEP        8'h03
`define CVC_HIGH_BASE        8'h18

`endif

// ===== logic/cvc_pkg.sv
// Purpose: types shared by the comparator control block
// Assumes: included defines give the numbers
// Notes:   no constants live here, only types
package cvc_pkg;

    // ============================================================
    // comparator control, writable part
    typedef struct packed {
        logic       second_result_invert;
        logic       first_result_invert;
        logic       input_switch_select;
        logic [2:0] comparator_mode_field;
    } cvc_cmp_ctrl_t;

    // ============================================================
    // reference ladder control
    typedef struct packed {
        logic       reference_ladder_enable;
        logic       reference_pin_output_enable;
        logic       reference_range_select;
        logic       reference_source_select;
        logic [3:0] reference_tap_value;
    } cvc_ref_ctrl_t;

endpackage : cvc_pkg

// ===== verification/cvc_cmp_model.sv
// Purpose: behavioural pair of analog comparators in front of the block
// Assumes: level_in says which input pair sits above its threshold
// Notes:   outputs move after a response delay, unrelated to the clock
`timescale 1ns/1ps

module cvc_cmp_model (
    // stimulus from the bench
    input  wire logic [1:0] level_in,
    input  wire logic [7:0] resp_ns_in,
    // comparator outputs, asynchronous to the core clock
    output logic      [1:0] raw_out
);

    // ============================================================
    // response delay; a change landing mid-delay shows at its end only,
    // which is how a slow comparator smears fast input wiggles
    initial raw_out = 2'h0;
    always @(level_in) begin
        #(resp_ns_in);
        raw_out = level_in;
    end

endmodule : cvc_cmp_model

// ===== verification/cvc_top_tb.sv
// Purpose: self-checking bench for the comparator change and ladder block
// Assumes: zero wait state slave, results reach the flag within 8 cycles
// Notes:   register access only through the AHB-Lite tasks below
`timescale 1ns/1ps
`include "cvc_defines.svh"

module cvc_top_tb;

    logic              clk, rst, hsel, hwrite, sleep;
    logic        [7:0] haddr, resp, v;
    logic        [1:0] htrans, level;
    logic        [2:0] hsize;
    logic       [31:0] hwdata, rdv;
    logic        [7:0] pe [4], ce [4], lt [4];
    wire logic         hready, hresp, irq, prio, wake, analog;
    wire logic  [31:0] hrdata;
    wire logic   [1:0] raw;
    wire logic   [5:0] cmpc;
    wire logic   [7:0] refc, lvl, pdir;
    int                n_mismatch, checks, cyc, i;

    // ============================================================
    // design and comparator model
    cvc_top dut (.CLK_IN(clk), .RST_IN(rst), .HSEL_IN(hsel),
        .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
        .HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(hready),
        .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .HRDATA_OUT(hrdata),
        .CMP_RAW_IN(raw), .SLEEP_IN(sleep), .CMP_CTRL_OUT(cmpc),
        .REF_CTRL_OUT(refc), .REF_LEVEL_OUT(lvl), .PORTF_DIR_OUT(pdir),
        .PINS_ANALOG_OUT(analog), .IRQ_OUT(irq), .IRQ_PRIO_OUT(prio),
        .WAKE_OUT(wake));
    cvc_cmp_model cmp (.level_in(level), .resp_ns_in(resp), .raw_out(raw));

    // ============================================================
    // 200 MHz clock and a hang guard well above the ~160 cycles needed
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e,
                       input string m);
        checks++;
        if (g !== e) begin
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
            n_mismatch++;
        end
    endtask : chk

    // one single transfer; the master waits on hready, never a count
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rdv = hrdata;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string m);
        xfer(1'b0, a, 32'h0);
        chk(rdv, e, m);
    endtask : rd

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    // ============================================================
    // main sequence
    initial begin
        {clk, hwrite, sleep, htrans, level} = '0;
        {haddr, hwdata, n_mismatch, checks, cyc} = '0;
        rst = 1'b1;
        hsel = 1'b1;
        hsize = 3'h2;
        resp = 8'h01;
        pe = '{8'h40, 8'h00, 8'h40, 8'h40};
        ce = '{8'hC0, 8'hC0, 8'h40, 8'h80};
        lt = '{8'hA0, 8'hAF, 8'h90, 8'hDF};
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // reset state
        rd(`CVC_OFS_CMP_CTRL, 32'h07, "ctrl reset");
        rd(`CVC_OFS_REF_CTRL, 32'h00, "ladder reset");
        chk(cmpc, 32'h07, "ctrl out reset");
        chk(analog, 32'h1, "pins analog");
        $display("test reset done");
        // change detection with all enables clear, refused clear
        wr(`CVC_OFS_CMP_CTRL, 32'h02);
        level <= 2'h1;
        tick(8);
        rd(`CVC_OFS_REQ_FLAGS2, 32'h40, "flag on change");
        chk(irq, 32'h0, "irq while disabled");
        wr(`CVC_OFS_REQ_FLAGS2, 32'h00);
        rd(`CVC_OFS_REQ_FLAGS2, 32'h40, "clear in mismatch");
        wr(`CVC_OFS_CMP_CTRL, 32'hC2);
        wr(`CVC_OFS_REQ_FLAGS2, 32'h00);
        tick(4);
        rd(`CVC_OFS_REQ_FLAGS2, 32'h00, "clear after relatch");
        rd(`CVC_OFS_CMP_CTRL, 32'h42, "results readable");
        $display("test change flag done");
        // simulated request and the three enable levels
        wr(`CVC_OFS_REQ_FLAGS2, 32'h40);
        rd(`CVC_OFS_REQ_FLAGS2, 32'h40, "flag forced");
        for (i = 0; i < 4; i++) begin
            wr(`CVC_OFS_REQ_EN2, {24'h0, pe[i]});
            wr(`CVC_OFS_CORE_IRQ, {24'h0, ce[i]});
            tick(3);
            chk(irq, {31'h0, i == 0}, "irq gating");
        end
        rd(`CVC_OFS_REQ_FLAGS2, 32'h40, "flag kept");
        wr(`CVC_OFS_REQ_PRIO2, 32'h40);
        tick(3);
        chk(prio, 32'h1, "priority bit");
        $display("test enables done");
        // wake from sleep on a slow second comparator change
        wr(`CVC_OFS_REQ_FLAGS2, 32'h00);
        resp <= 8'h17;
        sleep <= 1'b1;
        tick(3);
        chk(wake, 32'h0, "no wake");
        level <= 2'h3;
        tick(14);
        chk(wake, 32'h1, "wake on change");
        sleep <= 1'b0;
        rd(`CVC_OFS_CMP_CTRL, 32'hC2, "ctrl after sleep");
        $display("test sleep done");
        // ladder range, tap, source and pin override
        wr(`CVC_OFS_PORTF_DIR, 32'h00);
        for (i = 0; i < 4; i++) begin
            v = lt[i];
            wr(`CVC_OFS_REF_CTRL, {24'h0, v});
            tick(3);
            chk(lvl, v[5] ? 4 * v[3:0] : 24 + 3 * v[3:0],
                "level");
            chk(refc, v, "ladder out");
            chk(pdir[5], v[6], "pin override");
            rd(`CVC_OFS_REF_CTRL, {24'h0, v}, "ladder read");
        end
        $display("test ladder done");
        // port configuration and unmapped space
        wr(`CVC_OFS_CONV_CFG, 32'h0F);
        tick(3);
        chk(analog, 32'h0, "pins digital");
        wr(`CVC_OFS_CONV_CFG, 32'h03);
        tick(3);
        chk(analog, 32'h1, "pins analog again");
        rd(8'h20, 32'h0, "unmapped");
        wr(`CVC_OFS_CMP_CTRL, 32'h07);
        rd(`CVC_OFS_CMP_CTRL, 32'h07, "mode off");
        $display("test config done");
        // second reset in mid-run brings the ladder and flag back to defaults
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(`CVC_OFS_REF_CTRL, 32'h00, "ladder after reset");
        rd(`CVC_OFS_REQ_FLAGS2, 32'h00, "flag after reset");
        rd(`CVC_OFS_CMP_CTRL, 32'h07, "ctrl after reset");
        chk(pdir, 32'hFF, "port dir after reset");
        chk(hresp, 32'h0, "okay response");
        $display("test mid-run reset done");
        complete_run();
    end

endmodule : cvc_top_tb
